// ===== shared/osram_defines.svh
/*
 * Constants of the on-chip SRAM port control: register field positions,
 * reset values, array geometry and access-space codes.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef OSRAM_DEFINES_SVH
`define OSRAM_DEFINES_SVH

// Base and configuration register fields
`define OSRAM_BA_HI        31
`define OSRAM_BA_LO        16
`define OSRAM_PRI_UP_BIT   11
`define OSRAM_PRI_LO_BIT   10
`define OSRAM_SPV_BIT      9
`define OSRAM_WP_BIT       8
`define OSRAM_MASK_HI      5
`define OSRAM_MASK_LO      1
`define OSRAM_VALID_BIT    0
`define OSRAM_DEFINED_BITS 32'hffff_0f3f
`define OSRAM_CFG_RESET    32'h0000_0000

// Array geometry: two banks of 32 Kbyte, 32-bit words
`define OSRAM_BANK_SEL_BIT 15
`define OSRAM_WADDR_HI     14
`define OSRAM_WADDR_LO     2
`define OSRAM_WADDR_W      13
`define OSRAM_DEPTH        8192

// Access-space codes, mask bit index within bits 5..1
`define OSRAM_SP_UDATA     3'h0
`define OSRAM_SP_UCODE     3'h1
`define OSRAM_SP_SDATA     3'h2
`define OSRAM_SP_SCODE     3'h3
`define OSRAM_SP_CPU       3'h4

`endif

// ===== shared/osram_pkg.sv
/*
 * Types of the on-chip SRAM port control.
 * Assumes osram_defines.svh on the include path.
 */
`include "osram_defines.svh"

package osram_pkg;

    // Access space presented with each core or debug request
    typedef enum logic [2:0] {
        OSRAM_UDATA = 3'b000,
        OSRAM_UCODE = 3'b001,
        OSRAM_SDATA = 3'b010,
        OSRAM_SCODE = 3'b011,
        OSRAM_CPU   = 3'b100
    } osram_space_e;

    // Read-answer sequencer per port
    typedef enum logic [0:0] {
        OSRAM_IDLE = 1'b0,
        OSRAM_ANS  = 1'b1
    } osram_state_e;

    typedef logic [31:0] osram_word_t;

endpackage : osram_pkg

// ===== design/osram_bank.sv
/*
 * One physical 32-Kbyte SRAM bank with two ports, byte write enables
 * and registered read data. Contents are not reset.
 * Assumes a single clock; simultaneous writes to one word are resolved
 * upstream by the bank priority logic.
 */
`timescale 1ns/10ps
`include "osram_defines.svh"

module osram_bank (
    // Clock
    input  wire logic                       mclk,
    // Port A
    input  wire logic                       a_en,
    input  wire logic [3:0]                 a_we,
    input  wire logic [`OSRAM_WADDR_W-1:0]  a_addr,
    input  wire logic [31:0]                a_wdata,
    output logic      [31:0]                a_rdata,
    // Port B
    input  wire logic                       b_en,
    input  wire logic [3:0]                 b_we,
    input  wire logic [`OSRAM_WADDR_W-1:0]  b_addr,
    input  wire logic [31:0]                b_wdata,
    output logic      [31:0]                b_rdata
);

    // Each byte lane owns its array, so a single process writes it
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            logic [7:0] mem [0:`OSRAM_DEPTH-1];
            logic [7:0] a_q;
            logic [7:0] b_q;

            // No reset on the array: contents stay undefined until written
            always_ff @(posedge mclk) begin
                if (a_en && a_we[g]) begin
                    mem[a_addr] <= a_wdata[g*8 +: 8];
                end else if (b_en && b_we[g]) begin
                    mem[b_addr] <= b_wdata[g*8 +: 8];
                end
                if (a_en) begin
                    a_q <= mem[a_addr];
                end
                if (b_en) begin
                    b_q <= mem[b_addr];
                end
            end

            // Registered lane data onto the word outputs
            assign a_rdata[g*8 +: 8] = a_q;
            assign b_rdata[g*8 +: 8] = b_q;
        end
    endgenerate

endmodule : osram_bank

// ===== design/osram_ctrl.sv
/*
 * Port control of the relocatable on-chip SRAM: base and configuration
 * register, hit decode, write protection, access-space masking, DMA
 * second port and per-bank priority over two physical banks.
 * Assumes core and debug requests arrive on the processor clock; the
 * debug port is granted by the core logic and never overlaps a core access.
 */
`timescale 1ns/10ps
`include "osram_defines.svh"

module osram_ctrl
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Register access from core control-register move and debug
    input  wire logic                 cfg_wr,
    input  wire logic                 dbg_cfg_wr,
    input  wire logic [31:0]          cfg_wdata,
    output logic      [31:0]          dbg_cfg_rdata,
    // Core or debug local-bus request
    input  wire logic                 cpu_req,
    input  wire logic                 cpu_wr,
    input  wire logic [3:0]           cpu_be,
    input  wire logic [31:0]          cpu_addr,
    input  wire logic [31:0]          cpu_wdata,
    input  wire osram_pkg::osram_space_e cpu_space,
    // Cache read data, used when the RAM does not hit
    input  wire logic [31:0]          cache_rdata,
    // Core answer
    output logic                      cpu_hit,
    output logic                      cpu_ack,
    output logic                      cpu_acc_err,
    output logic                      cpu_stall,
    output logic [31:0]               cpu_rdata,
    // DMA second port
    input  wire logic                 dma_req,
    input  wire logic                 dma_wr,
    input  wire logic [3:0]           dma_be,
    input  wire logic [31:0]          dma_addr,
    input  wire logic [31:0]          dma_wdata,
    output logic                      dma_ack,
    output logic                      dma_refused,
    output logic                      dma_stall,
    output logic [31:0]               dma_rdata
);
    import osram_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Base and configuration register

    logic        valid_q;
    logic [31:1] cfg_hi_q;
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;

    // Two registers, since only the valid bit sees reset
    assign cfg_q = {cfg_hi_q, valid_q};

    // Reserved bits never stored, so they read back zero
    assign cfg_d = cfg_wdata & `OSRAM_DEFINED_BITS;

    // Only the valid bit is reset; all others keep their value
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
        end else if (cfg_wr || dbg_cfg_wr) begin
            valid_q <= cfg_d[`OSRAM_VALID_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (cfg_wr || dbg_cfg_wr) begin
            cfg_hi_q <= cfg_d[31:1];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_cfg_rdata <= `OSRAM_CFG_RESET;
        end else begin
            dbg_cfg_rdata <= cfg_q & `OSRAM_DEFINED_BITS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Field decode

    wire        valid     = cfg_q[`OSRAM_VALID_BIT];
    wire        wprot     = cfg_q[`OSRAM_WP_BIT];
    wire        second_port_enable       = cfg_q[`OSRAM_SPV_BIT];
    wire        pri_up    = cfg_q[`OSRAM_PRI_UP_BIT];
    wire        pri_lo    = cfg_q[`OSRAM_PRI_LO_BIT];
    wire [15:0] base      = cfg_q[`OSRAM_BA_HI:`OSRAM_BA_LO];
    wire [4:0]  space_mask_bits = cfg_q[`OSRAM_MASK_HI:`OSRAM_MASK_LO];

    // Mask bit that governs one space, highest bit for CPU/iack
    function automatic logic space_masked(input logic [4:0] m, input osram_space_e s);
        case (s)
            OSRAM_CPU:   space_masked = m[`OSRAM_SP_CPU];
            OSRAM_SCODE: space_masked = m[`OSRAM_SP_SCODE];
            OSRAM_SDATA: space_masked = m[`OSRAM_SP_SDATA];
            OSRAM_UCODE: space_masked = m[`OSRAM_SP_UCODE];
            OSRAM_UDATA: space_masked = m[`OSRAM_SP_UDATA];
            default:     space_masked = 1'b1;
        endcase
    endfunction : space_masked

    // Base match used by both ports
    function automatic logic base_match(input logic [31:0] a, input logic [15:0] b);
        base_match = (a[`OSRAM_BA_HI:`OSRAM_BA_LO] == b);
    endfunction : base_match

    ////////////////////////////////////////////////////////////////////
    // Hit, protection and bank selection

    wire cpu_in_ram  = cpu_req && valid && base_match(cpu_addr, base);
    wire cpu_hit_w   = cpu_in_ram && !space_masked(space_mask_bits, cpu_space);
    wire cpu_blocked = cpu_hit_w && cpu_wr && wprot;
    wire dma_in_ram  = dma_req && valid && base_match(dma_addr, base);
    wire dma_hit_w   = dma_in_ram && second_port_enable;
    wire dma_refuse  = dma_req && !dma_hit_w;

    wire cpu_bank = cpu_addr[`OSRAM_BANK_SEL_BIT];
    wire dma_bank = dma_addr[`OSRAM_BANK_SEL_BIT];

    // Same bank wanted by both: the bank's priority bit picks a winner
    wire clash     = cpu_hit_w && dma_hit_w && (cpu_bank == dma_bank);
    wire dma_first = dma_bank ? pri_up : pri_lo;
    wire cpu_go    = cpu_hit_w && !(clash && dma_first);
    wire dma_go    = dma_hit_w && !(clash && !dma_first);

    // Blocked writes reach no byte lane
    wire [3:0] cpu_we = (cpu_go && cpu_wr && !wprot) ? cpu_be : 4'h0;
    wire [3:0] dma_we = (dma_go && dma_wr) ? dma_be : 4'h0;

    ////////////////////////////////////////////////////////////////////
    // Two physical banks; core on port A, DMA on port B

    logic [31:0] rd_a [0:1];
    logic [31:0] rd_b [0:1];

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_bank
            // Separate arrays so core and DMA proceed in parallel
            osram_bank u_bank (
                .mclk    (mclk),
                .a_en    (cpu_go && (cpu_bank == 1'(g))),
                .a_we    (cpu_bank == 1'(g) ? cpu_we : 4'h0),
                .a_addr  (cpu_addr[`OSRAM_WADDR_HI:`OSRAM_WADDR_LO]),
                .a_wdata (cpu_wdata),
                .a_rdata (rd_a[g]),
                .b_en    (dma_go && (dma_bank == 1'(g))),
                .b_we    (dma_bank == 1'(g) ? dma_we : 4'h0),
                .b_addr  (dma_addr[`OSRAM_WADDR_HI:`OSRAM_WADDR_LO]),
                .b_wdata (dma_wdata),
                .b_rdata (rd_b[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Answer sequencing: array read data arrives one cycle later

    osram_state_e cst_q;
    osram_state_e dst_q;
    logic         cbank_q;
    logic         dbank_q;
    logic [31:0]  cache_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cst_q       <= OSRAM_IDLE;
            dst_q       <= OSRAM_IDLE;
            cbank_q     <= 1'b0;
            dbank_q     <= 1'b0;
            cache_q     <= 32'h0000_0000;
            cpu_hit     <= 1'b0;
            cpu_ack     <= 1'b0;
            cpu_acc_err <= 1'b0;
            cpu_stall   <= 1'b0;
            dma_ack     <= 1'b0;
            dma_refused <= 1'b0;
            dma_stall   <= 1'b0;
        end else begin
            cst_q       <= (cpu_go && !cpu_wr) ? OSRAM_ANS : OSRAM_IDLE;
            dst_q       <= (dma_go && !dma_wr) ? OSRAM_ANS : OSRAM_IDLE;
            cbank_q     <= cpu_bank;
            dbank_q     <= dma_bank;
            cache_q     <= cache_rdata;
            cpu_hit     <= cpu_hit_w;
            cpu_ack     <= cpu_go && !cpu_blocked;
            cpu_acc_err <= cpu_blocked;
            cpu_stall   <= cpu_hit_w && !cpu_go;
            dma_ack     <= dma_go;
            dma_refused <= dma_refuse;
            dma_stall   <= dma_hit_w && !dma_go;
        end
    end

    // RAM data replaces the cache result on a granted read hit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= 32'h0000_0000;
            dma_rdata <= 32'h0000_0000;
        end else begin
            cpu_rdata <= (cst_q == OSRAM_ANS) ? rd_a[cbank_q] : cache_q;
            dma_rdata <= (dst_q == OSRAM_ANS) ? rd_b[dbank_q] : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    AST_WP_ERR: assert property (@(posedge mclk) disable iff (!rst_n)
        (cpu_req && cpu_wr && valid && wprot && base_match(cpu_addr, base)
         && !space_masked(space_mask_bits, cpu_space)) |=> (cpu_acc_err && !cpu_ack))
        else $error("protected write not flagged");

    AST_DMA_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
        (dma_req && !second_port_enable) |=> (dma_refused && !dma_ack))
        else $error("DMA not refused while port disabled");

    AST_MASKED: assert property (@(posedge mclk) disable iff (!rst_n)
        (cpu_req && space_masked(space_mask_bits, cpu_space)) |=> !cpu_hit)
        else $error("masked space hit the RAM");

    AST_INVALID: assert property (@(posedge mclk) disable iff (!rst_n)
        !valid |=> (!cpu_hit && !dma_ack))
        else $error("RAM answered while invalid");

    AST_RD_SRC: assert property (@(posedge mclk) disable iff (!rst_n)
        (cpu_go && !cpu_wr) |=> ##1 (cpu_rdata == $past(rd_a[cbank_q])))
        else $error("RAM read data not selected");

    AST_PRIO: assert property (@(posedge mclk) disable iff (!rst_n)
        clash |-> (dma_first ? (dma_go && !cpu_go) : (cpu_go && !dma_go)))
        else $error("bank priority wrong");

    AST_RSVD: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 ((dbg_cfg_rdata & ~`OSRAM_DEFINED_BITS) == 32'h0000_0000))
        else $error("reserved bits read non-zero");

    AST_NO_WE: assert property (@(posedge mclk) disable iff (!rst_n)
        (wprot || !cpu_hit_w) |-> (cpu_we == 4'h0))
        else $error("blocked write reached the array");

endmodule : osram_ctrl

// ===== sim/osram_dma_model.sv
/* DMA bus master on the SRAM second port, driven through task xfer.
   Assumes one-cycle requests and registered answers one edge later. */
`timescale 1ns/10ps

module osram_dma_model (
    // Clock
    input  wire logic        mclk,
    // Request side
    output logic             dma_req,
    output logic             dma_wr,
    output logic [3:0]       dma_be,
    output logic [31:0]      dma_addr,
    output logic [31:0]      dma_wdata,
    // Answer side
    input  wire logic        dma_ack,
    input  wire logic        dma_refused,
    input  wire logic        dma_stall,
    input  wire logic [31:0] dma_rdata
);
    logic [2:0]  flags;
    logic [31:0] rdata;

    // Idle values at time zero
    initial begin
        dma_req   = 1'b0;
        dma_wr    = 1'b0;
        dma_be    = 4'hf;
        dma_addr  = 32'h0;
        dma_wdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One transfer; released lines show the inverse so stale data never matches
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(negedge mclk);
        dma_req   = 1'b1;
        dma_wr    = wr;
        dma_addr  = a;
        dma_wdata = wd;
        @(negedge mclk);
        flags     = {dma_ack, dma_refused, dma_stall};
        dma_req   = 1'b0;
        dma_addr  = ~a;
        dma_wdata = ~wd;
        @(negedge mclk);
        rdata     = dma_rdata;
    endtask : xfer
endmodule : osram_dma_model

// ===== sim/osram_ctrl_tb_top.sv
/* Self-checking bench of the SRAM port control: table of core accesses,
   then masks, protection, DMA port, bank clashes, debug path and reset.
   Assumes the design package and the DMA master model. */
`timescale 1ns/10ps
`include "osram_defines.svh"

module osram_ctrl_tb_top;
    import osram_pkg::*;
    typedef struct {logic wr; logic [3:0] be; logic [31:0] addr; logic [2:0] sp;
                    logic [31:0] wd; logic hit;} osram_row_s;
    logic         mclk, rst_n, cfg_wr, dbg_cfg_wr, cpu_req, cpu_wr;
    logic         cpu_hit, cpu_ack, cpu_acc_err, cpu_stall;
    logic         dma_req, dma_wr, dma_ack, dma_refused, dma_stall;
    logic [3:0]   cpu_be, dma_be, f;
    logic [31:0]  cfg_wdata, dbg_cfg_rdata, cpu_addr, cpu_wdata, cache_rdata;
    logic [31:0]  cpu_rdata, dma_addr, dma_wdata, dma_rdata, rd;
    osram_space_e cpu_space;
    int           error_cnt, n_tests;
    logic [31:0]  cfgs [3] = '{32'h0000_002b, 32'h0000_0035, 32'h0000_0021};
    // Read rows carry the expected word in the data column
    osram_row_s   rows [8] = '{
        '{1'b1, 4'hf, 32'h2000_0010, 3'h2, 32'h1111_aaaa, 1'b1},
        '{1'b1, 4'h1, 32'h2000_0010, 3'h2, 32'h0000_00ee, 1'b1},
        '{1'b0, 4'hf, 32'h2000_0010, 3'h2, 32'h1111_aaee, 1'b1},
        '{1'b1, 4'hf, 32'h2000_8010, 3'h0, 32'h2222_bbbb, 1'b1},
        '{1'b0, 4'hf, 32'h2000_8010, 3'h3, 32'h2222_bbbb, 1'b1},
        '{1'b0, 4'hf, 32'h2001_0010, 3'h2, 32'h0000_0000, 1'b0},
        '{1'b1, 4'hf, 32'h2000_fffc, 3'h1, 32'h3333_cccc, 1'b1},
        '{1'b0, 4'hf, 32'h2000_fffc, 3'h4, 32'h3333_cccc, 1'b1}};

    osram_ctrl dut (.mclk(mclk), .rst_n(rst_n), .cfg_wr(cfg_wr), .dbg_cfg_wr(dbg_cfg_wr),
        .cfg_wdata(cfg_wdata), .dbg_cfg_rdata(dbg_cfg_rdata), .cpu_req(cpu_req),
        .cpu_wr(cpu_wr), .cpu_be(cpu_be), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_space(cpu_space), .cache_rdata(cache_rdata), .cpu_hit(cpu_hit),
        .cpu_ack(cpu_ack), .cpu_acc_err(cpu_acc_err), .cpu_stall(cpu_stall),
        .cpu_rdata(cpu_rdata), .dma_req(dma_req), .dma_wr(dma_wr), .dma_be(dma_be),
        .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
        .dma_refused(dma_refused), .dma_stall(dma_stall), .dma_rdata(dma_rdata));
    osram_dma_model dma (.mclk(mclk), .dma_req(dma_req), .dma_wr(dma_wr), .dma_be(dma_be),
        .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_ack(dma_ack),
        .dma_refused(dma_refused), .dma_stall(dma_stall), .dma_rdata(dma_rdata));

    // Clock
    always #2 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: flags %b, expected %b", $time, got, exp);
        end
    endtask : chk_flag

    // Register write; readback lands two edges later
    task automatic cfg(input logic dbg, input logic [31:0] v);
        @(negedge mclk);
        cfg_wr     = !dbg;
        dbg_cfg_wr = dbg;
        cfg_wdata  = v;
        @(negedge mclk);
        cfg_wr     = 1'b0;
        dbg_cfg_wr = 1'b0;
        cfg_wdata  = ~v;
        @(negedge mclk);
        chk_word(dbg_cfg_rdata, v & `OSRAM_DEFINED_BITS);
    endtask : cfg

    // One core access; cache offers ~addr so a miss is recognisable
    task automatic cpu_op(input logic wr, input logic [3:0] be, input logic [31:0] a,
                          input logic [2:0] sp, input logic [31:0] wd);
        @(negedge mclk);
        cpu_req     = 1'b1;
        cpu_wr      = wr;
        cpu_be      = be;
        cpu_addr    = a;
        cpu_wdata   = wd;
        cpu_space   = osram_space_e'(sp);
        cache_rdata = ~a;
        @(negedge mclk);
        f           = {cpu_hit, cpu_ack, cpu_acc_err, cpu_stall};
        cpu_req     = 1'b0;
        cpu_addr    = ~a;
        cpu_wdata   = ~wd;
        cache_rdata = a;
        @(negedge mclk);
        rd          = cpu_rdata;
    endtask : cpu_op

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, far beyond the under two hundred cycles the sequence needs
    initial begin
        repeat (5000) @(posedge mclk);
        error_cnt++;
        summarize();
    end

    // Main sequence
    initial begin
        {mclk, rst_n, cfg_wr, dbg_cfg_wr, cpu_req, cpu_wr} = 6'h0;
        {cpu_be, cpu_addr, cpu_wdata, cfg_wdata, cache_rdata} = '0;
        cpu_space = OSRAM_UDATA;
        error_cnt = 0;
        n_tests   = 0;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        chk_word({31'h0, dbg_cfg_rdata[0]}, 32'h0);
        cpu_op(1'b0, 4'hf, 32'h2000_0010, 3'h2, 32'h0);
        chk_word(rd, ~32'h2000_0010);
        dma.xfer(1'b0, 32'h2000_0010, 32'h0);
        chk_flag({1'b0, dma.flags}, 4'b0010);
        cfg(1'b0, 32'h2000_f2c1);
        foreach (rows[i]) begin
            cpu_op(rows[i].wr, rows[i].be, rows[i].addr, rows[i].sp, rows[i].wd);
            chk_flag(f, {rows[i].hit, rows[i].hit, 2'b00});
            if (!rows[i].wr) chk_word(rd, rows[i].hit ? rows[i].wd : ~rows[i].addr);
        end
        foreach (cfgs[k]) begin
            cfg(1'b0, 32'h2000_0200 | cfgs[k]);
            for (int s = 0; s < 5; s++) begin
                cpu_op(1'b0, 4'hf, 32'h2000_0010, s[2:0], 32'h0);
                chk_word(rd, cfgs[k][s+1] ? ~32'h2000_0010 : 32'h1111_aaee);
            end
        end
        cfg(1'b0, 32'h2000_0301);
        cpu_op(1'b1, 4'hf, 32'h2000_0010, 3'h0, 32'hdead_beef);
        chk_flag(f, 4'b1010);
        cpu_op(1'b0, 4'hf, 32'h2000_0010, 3'h0, 32'h0);
        chk_word(rd, 32'h1111_aaee);
        cfg(1'b0, 32'h2000_0001);
        dma.xfer(1'b1, 32'h2000_8020, 32'h4444_dddd);
        chk_flag({1'b0, dma.flags}, 4'b0010);
        cfg(1'b0, 32'h2000_0201);
        dma.xfer(1'b1, 32'h2000_8020, 32'h4444_dddd);
        chk_flag({1'b0, dma.flags}, 4'b0100);
        dma.xfer(1'b0, 32'h3000_0000, 32'h0);
        chk_flag({1'b0, dma.flags}, 4'b0010);
        cpu_op(1'b0, 4'hf, 32'h2000_8020, 3'h2, 32'h0);
        chk_word(rd, 32'h4444_dddd);
        // Same-bank clashes: bit 11 rules the upper bank, bit 10 the lower
        for (int c = 0; c < 4; c++) begin
            cfg(1'b0, {16'h2000, 4'h0, c[1], !c[1], 10'h201});
            fork
                cpu_op(1'b0, 4'hf, {16'h2000, c[0], 15'h0010}, 3'h2, 32'h0);
                dma.xfer(1'b0, {16'h2000, c[0], 15'h0014}, 32'h0);
            join
            chk_flag({2'b00, f[0], dma.flags[0]}, {2'b00, c[0] == c[1], c[0] != c[1]});
        end
        fork
            cpu_op(1'b0, 4'hf, 32'h2000_0010, 3'h2, 32'h0);
            dma.xfer(1'b0, 32'h2000_8020, 32'h0);
        join
        chk_flag({2'b00, f[2], dma.flags[2]}, 4'b0011);
        chk_word(dma.rdata, 32'h4444_dddd);
        chk_word(rd, 32'h1111_aaee);
        cfg(1'b1, 32'h3000_0201);
        cpu_op(1'b0, 4'hf, 32'h3000_0010, 3'h2, 32'h0);
        chk_word(rd, 32'h1111_aaee);
        cpu_op(1'b0, 4'hf, 32'h2000_0010, 3'h2, 32'h0);
        chk_word(rd, ~32'h2000_0010);
        // Second reset in mid-run
        @(negedge mclk);
        rst_n = 1'b0;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        chk_word({31'h0, dbg_cfg_rdata[0]}, 32'h0);
        cpu_op(1'b0, 4'hf, 32'h3000_0010, 3'h2, 32'h0);
        chk_flag(f, 4'b0000);
        chk_word(rd, ~32'h3000_0010);
        summarize();
    end
endmodule : osram_ctrl_tb_top
